// *** hw/wpo_cfg.svh ***
// Constants for the weld process output selector.
// Assumes a 100 MHz system clock; included by the package and the design.
`ifndef WPO_CFG_SVH
`define WPO_CFG_SVH

// ----------------------------------------
// Selection codes
// ----------------------------------------
`define WPO_SEL_OFF        5'h00
`define WPO_SEL_WELD       5'h01
`define WPO_SEL_WELD_HOLD  5'h02
`define WPO_SEL_HOLD       5'h03
`define WPO_SEL_OFFPH      5'h04
`define WPO_SEL_AFTER_OFF  5'h05
`define WPO_SEL_EOS_PULSE  5'h06
`define WPO_SEL_ANY_ERR    5'h0A
`define WPO_SEL_OVERTEMP   5'h0B
`define WPO_SEL_HL_FLASH   5'h0C
`define WPO_SEL_HL_VALVE   5'h0D
`define WPO_SEL_HL_BREAK   5'h0E
`define WPO_SEL_HW_FAULT   5'h0F
`define WPO_SEL_SCR_SHORT  5'h10
`define WPO_SEL_MINOR      5'h11
`define WPO_SEL_FULL_COND  5'h12
`define WPO_SEL_WELD_EN    5'h13
`define WPO_SEL_INTERLOCK  5'h14
`define WPO_SEL_SERIAL     5'h16
`define WPO_SEL_SHOW_EOS   5'h19
`define WPO_SEL_EOS_VALVE  5'h1C

// ----------------------------------------
// Timing
// ----------------------------------------
`define WPO_CLK_HZ         100000000
`define WPO_PULSE_MS       500
`define WPO_PULSE_CYC      ((`WPO_CLK_HZ / 1000) * `WPO_PULSE_MS)
`define WPO_CNT_W          26
`define WPO_CNT_ZERO       26'h0000000
`define WPO_CNT_ONE        26'h0000001

`endif

// *** hw/wpo_pkg.sv ***
// Types shared by the weld process output selector.
// Assumes wpo_cfg.svh supplies the constants.
`include "wpo_cfg.svh"

package wpo_pkg;

    // Sequence phase as reported by the sequencer
    typedef enum logic [2:0] {
        WPO_PH_IDLE,
        WPO_PH_SQUEEZE,
        WPO_PH_WELD,
        WPO_PH_HOLD,
        WPO_PH_OFF
    } wpo_phase_t;

    // Fault and status flags from the control
    typedef struct packed {
        logic any_error;
        logic no_weld;
        logic programming;
        logic emergency_stop;
        logic hardware_fault;
        logic relay_fault;
        logic scr_shorted;
        logic second_supply_line_lost;
        logic memory_fault;
        logic voltage_comp_fault;
        logic stepper_end;
        logic full_conduction;
    } wpo_faults_t;

    // Current monitor result
    typedef struct packed {
        logic        valid;
        logic        const_current;
        logic        out_of_window;
        logic        high;
        logic [15:0] current;
    } wpo_meas_t;

    // Serial report word
    typedef struct packed {
        logic        high;
        logic        out_of_window;
        logic [15:0] current;
    } wpo_report_t;

endpackage

// *** hw/wpo_select.sv ***
// Weld process output selector: picks when the process output and its
// companions are energised from the stored selection code.
// Assumes sequencer, fault and monitor inputs are synchronous to mclk;
// only the pin inputs (overtemp, weld enable, initiation) are synchronised.
//
// What this block does
// - Codes 01-04: output on in weld, weld+hold, hold, off phase.
// - Code 05: output on after off completes until initiation released.
// - Code 06: half-second output pulse starting at end of sequence.
// - Code 10: output on for any error, no-weld, program, e-stop, window miss in constant current.
// - Code 11: output on while overtemperature switch reads open.
// - Code 12: flash high/low indicator on out-of-window current.
// - Code 13: flash indicator and half-second third valve on window miss.
// - Code 14: flash indicator and abort sequence on window miss.
// - Code 15: output on for hardware or control relay fault.
// - Code 16: output on for shorted thyristor or lost second supply line.
// - Code 17: output on for minor faults.
// - Code 18: output on when thyristor full conduction is detected.
// - Code 19: output on in weld phase, weld mode, weld enable closed.
// - Code 20: output on from squeeze end through weld, as interlock.
// - Code 22: send high/low and current after window miss or last weld.
// - Code 28: half-second valve pulse at end when in window and enabled.
`timescale 1ns/1ps
`default_nettype none
`include "wpo_cfg.svh"

module wpo_select (
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 reset_n,
    // Selection programming
    input  wire logic [4:0]           sel_code,
    input  wire logic                 sel_enter,
    // Sequence state
    input  wire wpo_pkg::wpo_phase_t  phase,
    input  wire logic                 sequence_finished_event,
    input  wire logic                 last_weld,
    input  wire logic                 weld_mode,
    // Faults and measurement
    input  wire wpo_pkg::wpo_faults_t faults,
    input  wire wpo_pkg::wpo_meas_t   meas,
    // Pins on terminal_strip_one, raw
    input  wire logic                 overtemp_switch_open,
    input  wire logic                 weld_enable_input_n,
    input  wire logic                 initiation,
    // Outputs
    output logic                      process_out,
    output logic                      third_valve,
    output logic                      hl_flash,
    output logic                      hl_indicate,
    output logic                      show_current,
    output logic                      sequence_abort,
    output logic                      report_valid,
    output wpo_pkg::wpo_report_t      report_data,
    output logic [4:0]                active_code
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;

    // Two flops per pin; first stage read only by the second
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
        end else begin
            pin_meta_reg <= {overtemp_switch_open, ~weld_enable_input_n, initiation};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    logic overtemp_open;
    logic weld_enabled;
    logic init_held;
    assign overtemp_open = pin_sync_reg[2];
    assign weld_enabled  = pin_sync_reg[1];
    assign init_held     = pin_sync_reg[0];

    // ----------------------------------------
    // Committed selection
    // ----------------------------------------
    logic [4:0] code_reg;

    // Only the enter strobe commits; edits in progress never leak out
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            code_reg <= `WPO_SEL_OFF;
        end else if (sel_enter) begin
            code_reg <= sel_code;
        end
    end
    assign active_code = code_reg;

    // ----------------------------------------
    // Phase tracking
    // ----------------------------------------
    logic in_weld;
    logic in_hold;
    logic in_off;
    logic off_done;
    logic after_off_reg;
    logic was_off_reg;
    logic window_miss;

    assign in_weld     = (phase == wpo_pkg::WPO_PH_WELD);
    assign in_hold     = (phase == wpo_pkg::WPO_PH_HOLD);
    assign in_off      = (phase == wpo_pkg::WPO_PH_OFF);
    assign off_done    = was_off_reg && !in_off;
    assign window_miss = meas.valid && meas.out_of_window;

    // Latch after the off phase ends; dropped once initiation goes away
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            was_off_reg   <= 1'b0;
            after_off_reg <= 1'b0;
        end else begin
            was_off_reg <= in_off;
            if (off_done && init_held) begin
                after_off_reg <= 1'b1;
            end else if (!init_held) begin
                after_off_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Half-second pulse timers
    // ----------------------------------------
    function automatic logic [`WPO_CNT_W-1:0] tick(input logic start,
                                                    input logic [`WPO_CNT_W-1:0] cnt);
        logic [`WPO_CNT_W-1:0] n;
        n = cnt;
        if (start) begin
            n = `WPO_CNT_W'(`WPO_PULSE_CYC);
        end else if (cnt != `WPO_CNT_ZERO) begin
            n = cnt - `WPO_CNT_ONE;
        end
        return n;
    endfunction

    logic [`WPO_CNT_W-1:0] out_cnt_reg;
    logic [`WPO_CNT_W-1:0] valve_cnt_reg;
    logic                  out_start;
    logic                  valve_start;

    assign out_start = (code_reg == `WPO_SEL_EOS_PULSE) && sequence_finished_event;
    // Valve pulse: window miss for 13, good in-window end for 28
    assign valve_start = ((code_reg == `WPO_SEL_HL_VALVE) && window_miss)
                      || ((code_reg == `WPO_SEL_EOS_VALVE) && sequence_finished_event
                          && !meas.out_of_window && weld_mode && weld_enabled);

    // Counters run off mclk; a retrigger restarts the full half second
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            out_cnt_reg   <= `WPO_CNT_ZERO;
            valve_cnt_reg <= `WPO_CNT_ZERO;
        end else begin
            out_cnt_reg   <= tick(out_start, out_cnt_reg);
            valve_cnt_reg <= tick(valve_start, valve_cnt_reg);
        end
    end

    // ----------------------------------------
    // Output selection
    // ----------------------------------------
    logic po_next;
    logic flash_next;
    logic abort_next;

    // Combinational per-code decode, re-evaluated every cycle
    always_comb begin
        po_next    = 1'b0;
        flash_next = 1'b0;
        abort_next = 1'b0;
        unique case (code_reg)
            `WPO_SEL_WELD:      po_next = in_weld;
            `WPO_SEL_WELD_HOLD: po_next = in_weld || in_hold;
            `WPO_SEL_HOLD:      po_next = in_hold;
            `WPO_SEL_OFFPH:     po_next = in_off;
            `WPO_SEL_AFTER_OFF: po_next = after_off_reg;
            `WPO_SEL_EOS_PULSE: po_next = (out_cnt_reg != `WPO_CNT_ZERO);
            `WPO_SEL_ANY_ERR:   po_next = faults.any_error || faults.no_weld || faults.programming
                                       || faults.emergency_stop
                                       || (meas.const_current && window_miss);
            `WPO_SEL_OVERTEMP:  po_next = overtemp_open;
            `WPO_SEL_HL_FLASH:  flash_next = window_miss;
            `WPO_SEL_HL_VALVE:  flash_next = window_miss;
            `WPO_SEL_HL_BREAK: begin
                flash_next = window_miss;
                abort_next = window_miss;
            end
            `WPO_SEL_HW_FAULT:  po_next = faults.hardware_fault || faults.relay_fault;
            `WPO_SEL_SCR_SHORT: po_next = faults.scr_shorted || faults.second_supply_line_lost;
            `WPO_SEL_MINOR:     po_next = overtemp_open || faults.memory_fault
                                       || faults.voltage_comp_fault || faults.stepper_end;
            `WPO_SEL_FULL_COND: po_next = faults.full_conduction;
            `WPO_SEL_WELD_EN:   po_next = in_weld && weld_mode && weld_enabled;
            `WPO_SEL_INTERLOCK: po_next = in_weld;
            default:            po_next = 1'b0;
        endcase
    end

    // Registered outputs keep glitches off lamps and relays
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            process_out    <= 1'b0;
            hl_flash       <= 1'b0;
            sequence_abort <= 1'b0;
            third_valve    <= 1'b0;
        end else begin
            process_out    <= po_next;
            hl_flash       <= flash_next;
            sequence_abort <= abort_next;
            third_valve    <= (valve_cnt_reg != `WPO_CNT_ZERO) || valve_start;
        end
    end

    // ----------------------------------------
    // Indication, display and serial report
    // ----------------------------------------
    logic is_show;
    logic is_serial;
    assign is_show   = (code_reg == `WPO_SEL_SHOW_EOS);
    assign is_serial = (code_reg == `WPO_SEL_SERIAL);

    // Indicator held from end of sequence until the next end of sequence
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            hl_indicate  <= 1'b0;
            show_current <= 1'b0;
        end else begin
            show_current <= is_show;
            if (!is_show) begin
                hl_indicate <= 1'b0;
            end else if (sequence_finished_event) begin
                hl_indicate <= meas.out_of_window;
            end
        end
    end

    // One-cycle report strobe with data from flops
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            report_valid <= 1'b0;
            report_data  <= '0;
        end else begin
            report_valid <= is_serial && meas.valid && (meas.out_of_window || last_weld);
            if (meas.valid) begin
                report_data <= '{high: meas.high, out_of_window: meas.out_of_window,
                                 current: meas.current};
            end
        end
    end

endmodule
`default_nettype wire

// *** verification/wpo_select_checker.sv ***
// Concurrent checks on the weld process output selector.
// Assumes it is bound to wpo_select and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module wpo_select_checker (
    // Clock and reset
    input wire logic                 mclk,
    input wire logic                 reset_n,
    // Watched inputs
    input wire logic [4:0]           sel_code,
    input wire logic                 sel_enter,
    input wire wpo_pkg::wpo_phase_t  phase,
    input wire logic                 sequence_finished_event,
    input wire wpo_pkg::wpo_faults_t faults,
    input wire wpo_pkg::wpo_meas_t   meas,
    // Watched outputs
    input wire logic                 process_out,
    input wire logic                 report_valid,
    input wire wpo_pkg::wpo_report_t report_data,
    input wire logic [4:0]           active_code
);
    // ----------------------------------------
    // Output relations, one cycle after cause (two for the end pulse)
    // ----------------------------------------
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    AST_COMMIT: assert property (sel_enter |=> active_code == $past(sel_code))
        else $error("committed code differs from strobed code");
    AST_WELD: assert property (active_code == 5'h01 |=> process_out == ($past(phase) == wpo_pkg::WPO_PH_WELD))
        else $error("weld phase output wrong");
    AST_WELD_HOLD: assert property (
        active_code == 5'h02 |=> process_out == ($past(phase) inside {wpo_pkg::WPO_PH_WELD, wpo_pkg::WPO_PH_HOLD}))
        else $error("weld and hold output wrong");
    AST_OFF: assert property (active_code == 5'h04 |=> process_out == ($past(phase) == wpo_pkg::WPO_PH_OFF))
        else $error("off phase output wrong");
    AST_EOS: assert property (active_code == 5'h06 && sequence_finished_event |-> ##2 process_out)
        else $error("end pulse did not start");
    AST_ERR: assert property (active_code == 5'h0A && (|faults[11:8]) |=> process_out)
        else $error("error output missing");
    AST_HW: assert property (active_code == 5'h0F |=> process_out == $past(|faults[7:6]))
        else $error("hardware fault output wrong");
    AST_SCR: assert property (active_code == 5'h10 |=> process_out == $past(|faults[5:4]))
        else $error("thyristor fault output wrong");
    AST_COND: assert property (active_code == 5'h12 |=> process_out == $past(faults.full_conduction))
        else $error("full conduction output wrong");
    AST_IDLE: assert property (
        active_code inside {5'h00, 5'h07, 5'h08, 5'h09, 5'h15, 5'h17, 5'h18, 5'h1A, 5'h1B, 5'h1D, 5'h1E, 5'h1F}
        |=> !process_out)
        else $error("disabled code drives output");
    AST_REPORT: assert property (
        active_code == 5'h16 && meas.valid && meas.out_of_window
        |=> report_valid && report_data == {$past(meas.high), 1'b1, $past(meas.current)})
        else $error("serial report wrong");
endmodule
bind wpo_select wpo_select_checker chk_u (
    .mclk(mclk), .reset_n(reset_n), .sel_code(sel_code), .sel_enter(sel_enter), .phase(phase),
    .sequence_finished_event(sequence_finished_event), .faults(faults), .meas(meas),
    .process_out(process_out), .report_valid(report_valid), .report_data(report_data), .active_code(active_code)
);
`default_nettype wire

// *** verification/wpo_select_test.sv ***
// Self-checking bench for the weld process output selector.
// Assumes the package, design, checker and sequencer model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module wpo_select_test;
    logic                 mclk = 1'b0;
    logic                 reset_n = 1'b0;
    logic [4:0]           sel_code = 5'h00;
    logic                 sel_enter = 1'b0;
    logic                 start = 1'b0;
    logic                 weld_mode = 1'b1;
    logic                 last_weld = 1'b0;
    logic                 ot_open = 1'b0;
    logic                 en_n = 1'b1;
    logic                 init = 1'b0;
    wpo_pkg::wpo_faults_t faults = '0;
    wpo_pkg::wpo_meas_t   meas = '0;
    wpo_pkg::wpo_phase_t  phase;
    wpo_pkg::wpo_phase_t  ph_s;
    wpo_pkg::wpo_report_t report_data;
    logic                 seq_done, process_out, third_valve, hl_flash, sequence_abort, report_valid;
    logic                 hl_indicate, show_current;
    logic [4:0]           active_code;
    int                   bad_count = 0;
    int                   checks_done = 0;
    int                   cycles = 0;
    logic [4:0]           pc [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h13, 5'h14, 5'h00, 5'h1F};
    logic [4:0]           fc [5] = '{5'h0A, 5'h0F, 5'h10, 5'h11, 5'h12};
    logic [11:0]          fm [5] = '{12'hF00, 12'h0C0, 12'h030, 12'h00E, 12'h001};

    // ----------------------------------------
    // Clock, design, sequencer, timeout
    // ----------------------------------------
    always #5 mclk = ~mclk;
    always @(posedge mclk) ph_s <= phase;
    wpo_select dut_u (.mclk(mclk), .reset_n(reset_n), .sel_code(sel_code), .sel_enter(sel_enter), .phase(phase),
        .sequence_finished_event(seq_done), .last_weld(last_weld), .weld_mode(weld_mode), .faults(faults),
        .meas(meas), .overtemp_switch_open(ot_open), .weld_enable_input_n(en_n), .initiation(init),
        .process_out(process_out), .third_valve(third_valve), .hl_flash(hl_flash), .hl_indicate(hl_indicate),
        .show_current(show_current), .sequence_abort(sequence_abort), .report_valid(report_valid),
        .report_data(report_data), .active_code(active_code));
    wpo_seq_model seq_u (.mclk(mclk), .reset_n(reset_n), .start(start), .abort(sequence_abort),
        .phase(phase), .done(seq_done));
    // The whole run needs about 840 cycles; a hang is cut well beyond that
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 8000) begin
            bad_count++;
            final_report();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [17:0] seen, input logic [17:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic do_reset();
        reset_n = 1'b0;
        wait_n(20);
        reset_n = 1'b1;
        wait_n(3);
    endtask
    task automatic commit(input logic [4:0] code);
        sel_code = code;
        sel_enter = 1'b1;
        @(negedge mclk);
        sel_enter = 1'b0;
        @(negedge mclk);
    endtask
    task automatic kick();
        start = 1'b1;
        @(negedge mclk);
        start = 1'b0;
    endtask
    task automatic wait_done();
        repeat (40) begin
            @(negedge mclk);
            if (seq_done === 1'b1) break;
        end
    endtask
    task automatic pulse_meas(input logic oow);
        meas = '{valid: 1'b1, const_current: 1'b1, out_of_window: oow, high: 1'b1, current: 16'h1234};
        @(negedge mclk);
        meas.valid = 1'b0;
    endtask
    function automatic logic exp_phase(input logic [4:0] c, input wpo_pkg::wpo_phase_t p);
        case (c)
            5'h01, 5'h14: return p == wpo_pkg::WPO_PH_WELD;
            5'h02: return p == wpo_pkg::WPO_PH_WELD || p == wpo_pkg::WPO_PH_HOLD;
            5'h03: return p == wpo_pkg::WPO_PH_HOLD;
            5'h04: return p == wpo_pkg::WPO_PH_OFF;
            5'h13: return p == wpo_pkg::WPO_PH_WELD && weld_mode && !en_n;
            default: return 1'b0;
        endcase
    endfunction
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        do_reset();
        chk("reset outputs", {process_out, third_valve, active_code}, 18'h0);
        sel_code = 5'h03;
        wait_n(2);
        chk("code without enter", active_code, 5'h00);
        // Phase table over whole sequences, weld enable closed then open
        for (int pass = 0; pass < 2; pass++) begin
            en_n = pass[0];
            foreach (pc[k]) begin
                commit(pc[k]);
                kick();
                repeat (22) begin
                    @(negedge mclk);
                    chk("phase output", process_out, exp_phase(pc[k], ph_s));
                end
            end
        end
        // One fault flag at a time against each fault code
        foreach (fc[k]) begin
            commit(fc[k]);
            for (int i = 0; i < 12; i++) begin
                faults = 12'h001 << i;
                wait_n(2);
                chk("fault output", process_out, fm[k][i]);
            end
            faults = '0;
        end
        commit(5'h0B);
        ot_open = 1'b1;
        wait_n(4);
        chk("overtemp output", process_out, 1'b1);
        commit(5'h11);
        chk("minor overtemp", process_out, 1'b1);
        ot_open = 1'b0;
        wait_n(4);
        chk("minor cleared", process_out, 1'b0);
        commit(5'h05);
        init = 1'b1;
        wait_n(3);
        kick();
        wait_done();
        wait_n(4);
        chk("after off held", process_out, 1'b1);
        init = 1'b0;
        wait_n(5);
        chk("after off released", process_out, 1'b0);
        commit(5'h06);
        kick();
        wait_done();
        wait_n(3);
        chk("end pulse start", process_out, 1'b1);
        wait_n(100);
        chk("end pulse held", process_out, 1'b1);
        do_reset();
        chk("reset mid pulse", {process_out, active_code}, 18'h0);
        commit(5'h0D);
        pulse_meas(1'b1);
        chk("flash on miss", hl_flash, 1'b1);
        wait_n(2);
        chk("valve on miss", third_valve, 1'b1);
        commit(5'h16);
        pulse_meas(1'b1);
        chk("report valid", report_valid, 1'b1);
        chk("report data", report_data, 18'h31234);
        // Last weld reports even in window; an in-window ordinary weld stays quiet
        last_weld = 1'b1;
        wait_n(1);
        pulse_meas(1'b0);
        chk("report last weld", report_valid, 1'b1);
        last_weld = 1'b0;
        wait_n(1);
        pulse_meas(1'b0);
        chk("report in window", report_valid, 1'b0);
        commit(5'h0C);
        pulse_meas(1'b1);
        chk("flash without output", {hl_flash, process_out}, 2'h2);
        commit(5'h19);
        kick();
        wait_done();
        wait_n(2);
        chk("indicate at end", {hl_indicate, show_current}, 2'h3);
        commit(5'h0E);
        meas.out_of_window = 1'b0;
        kick();
        wait_n(5);
        pulse_meas(1'b1);
        wait_n(3);
        chk("aborted phase", phase, wpo_pkg::WPO_PH_IDLE);
        do_reset();
        commit(5'h1C);
        meas.out_of_window = 1'b0;
        en_n = 1'b0;
        kick();
        wait_done();
        wait_n(3);
        chk("valve at end", third_valve, 1'b1);
        final_report();
    end
endmodule
`default_nettype wire

// *** verification/wpo_seq_model.sv ***
// Sequencer model: walks the weld phases and ends with a one-cycle finish.
// Assumes one clock shared with the selector; an abort request wins.
`timescale 1ns/1ps
`default_nettype none
module wpo_seq_model (
    // Clock and reset
    input  wire logic               mclk,
    input  wire logic               reset_n,
    // Requests
    input  wire logic               start,
    input  wire logic               abort,
    // Sequence state
    output var wpo_pkg::wpo_phase_t phase,
    output logic                    done
);
    logic [1:0] cnt;
    // Four cycles a phase keeps runs short; abort drops to idle with no finish
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            phase <= wpo_pkg::WPO_PH_IDLE;
            cnt <= 2'h0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            cnt <= cnt + 2'h1;
            if (abort) begin
                phase <= wpo_pkg::WPO_PH_IDLE;
            end else if (phase == wpo_pkg::WPO_PH_IDLE) begin
                cnt <= 2'h0;
                if (start) begin
                    phase <= wpo_pkg::WPO_PH_SQUEEZE;
                end
            end else if (cnt == 2'h3) begin
                done <= (phase == wpo_pkg::WPO_PH_OFF);
                phase <= (phase == wpo_pkg::WPO_PH_OFF) ? wpo_pkg::WPO_PH_IDLE : wpo_pkg::wpo_phase_t'(phase + 3'h1);
            end
        end
    end
endmodule
`default_nettype wire
